// ---- dpci_top.sv ----
// drive profile command interpreter with AHB-Lite register slave
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dpci_top #(
    parameter int NSRC = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NSRC*16-1:0] srcWords,
    input wire logic errDetect,
    output logic motorRun,
    output logic freewheel,
    output logic velocityMode,
    output logic [15:0] funcOut
);
    typedef enum logic [6:0] {
        S_INIT = 7'h01, S_SOD = 7'h02, S_RTSO = 7'h04, S_SO = 7'h08,
        S_OE = 7'h10, S_QS = 7'h20, S_FLT = 7'h40
    } dpci_state_t;

    logic [31:0] ctrl_r;
    logic [15:0] cmd_r;
    logic [31:0] ref_r;
    logic [63:0] assign_r;
    logic refSeen_r;
    logic profile_r;
    logic [2:0] initCnt_r;
    dpci_state_t state_r;
    logic [15:0] drive_state_word;
    logic [15:0] cw;
    logic [7:0] aAddr_r;
    logic aWr_r;
    logic aVal_r;
    logic take;
    logic [15:0] funcMap;
    logic cmdWrite;
    logic refWrite;
    logic cfgWrite;

    // address phase capture
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge clk) begin
        if (rst) begin
            aVal_r <= 1'b0;
            aWr_r <= 1'b0;
            aAddr_r <= 8'h00;
        end else if (hready) begin
            aVal_r <= take;
            aWr_r <= hwrite;
            aAddr_r <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cmdWrite = aVal_r && aWr_r && aAddr_r == dpci_pkg::OFS_CMD;
    assign refWrite = aVal_r && aWr_r && aAddr_r == dpci_pkg::OFS_REF;
    assign cfgWrite = aVal_r && aWr_r &&
        (aAddr_r == dpci_pkg::OFS_CTRL || aAddr_r == dpci_pkg::OFS_ASSIGN ||
         aAddr_r == dpci_pkg::OFS_ASSIGN_HI);

    // software registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= dpci_pkg::CTRL_RESET;
            cmd_r <= 16'h0000;
            ref_r <= 32'h0000_0000;
            assign_r <= 64'h0000_0000_0000_0000;
        end else begin
            if (aVal_r && aWr_r && aAddr_r == dpci_pkg::OFS_CTRL) ctrl_r <= hwdata;
            if (cmdWrite) cmd_r <= hwdata[15:0];
            if (refWrite) ref_r <= hwdata;
            if (aVal_r && aWr_r && aAddr_r == dpci_pkg::OFS_ASSIGN) assign_r[31:0] <= hwdata;
            if (aVal_r && aWr_r && aAddr_r == dpci_pkg::OFS_ASSIGN_HI) begin
                assign_r[63:32] <= hwdata;
            end
        end
    end

    // merge every command source into one control word
    always_comb begin
        cw = cmd_r;
        for (int s = 0; s < NSRC; s++) begin
            cw = cw | srcWords[s*16 +: 16];
        end
    end

    // reference seen on the command channel
    always_ff @(posedge clk) begin
        if (rst) begin
            refSeen_r <= 1'b0;
        end else if (refWrite) begin
            refSeen_r <= 1'b1;
        end
    end

    // init counter and profile sampled on each init cycle, then held
    always_ff @(posedge clk) begin
        if (rst) begin
            initCnt_r <= 3'h0;
            profile_r <= 1'b0;
        end else if (initCnt_r != dpci_pkg::INIT_CNT_W) begin
            initCnt_r <= initCnt_r + 3'h1;
            profile_r <= ctrl_r[dpci_pkg::CTRL_PROFILE];
        end
    end

    // operating state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= S_INIT;
        end else if (errDetect || ctrl_r[dpci_pkg::CTRL_FAULT]) begin
            state_r <= S_FLT;
        end else begin
            unique case (state_r)
                S_INIT: begin
                    if (initCnt_r == dpci_pkg::INIT_CNT_W) state_r <= S_SOD;
                end
                S_SOD: begin
                    if (cw[dpci_pkg::CW_ENVOLT] && cw[dpci_pkg::CW_QUICKSTOP] &&
                        !cw[dpci_pkg::CW_SWITCHON]) state_r <= S_RTSO;
                end
                S_RTSO: begin
                    if (!cw[dpci_pkg::CW_ENVOLT]) state_r <= S_SOD;
                    else if (cw[dpci_pkg::CW_SWITCHON] && cw[dpci_pkg::CW_QUICKSTOP])
                        state_r <= S_SO;
                end
                S_SO: begin
                    if (cfgWrite || !cw[dpci_pkg::CW_ENVOLT]) state_r <= S_SOD;
                    else if (!cw[dpci_pkg::CW_SWITCHON]) state_r <= S_RTSO;
                    else if (cw[dpci_pkg::CW_ENOP] &&
                        (ctrl_r[dpci_pkg::CTRL_SEPARATE] || refSeen_r)) state_r <= S_OE;
                end
                S_OE: begin
                    if (!cw[dpci_pkg::CW_ENVOLT]) state_r <= S_SOD;
                    else if (!cw[dpci_pkg::CW_QUICKSTOP]) state_r <= S_QS;
                    else if (!cw[dpci_pkg::CW_ENOP]) begin
                        state_r <= ctrl_r[dpci_pkg::CTRL_STOPREACT] ? S_SOD : S_SO;
                    end
                end
                S_QS: begin
                    if (!cw[dpci_pkg::CW_ENVOLT]) state_r <= S_SOD;
                end
                S_FLT: begin
                    if (cw[dpci_pkg::CW_FAULTRST] || ctrl_r[dpci_pkg::CTRL_FAULTRST]) state_r <= S_SOD;
                end
                default: state_r <= S_INIT;
            endcase
        end
    end

    // status word encoding, init reported as disabled
    always_comb begin
        unique case (state_r)
            S_RTSO: drive_state_word = dpci_pkg::SW_RTSO;
            S_SO: drive_state_word = dpci_pkg::SW_SO;
            S_OE: drive_state_word = dpci_pkg::SW_OE;
            S_QS: drive_state_word = dpci_pkg::SW_QS;
            S_FLT: drive_state_word = dpci_pkg::SW_FLT;
            default: drive_state_word = dpci_pkg::SW_SOD;
        endcase
    end

    // function map for assignable bits
    dpci_func_map #(.NFUNC(16)) dpci_func_map_i (
        .ctrlWord(cw),
        .assignMap(assign_r),
        .firstFree(profile_r),
        .funcOut(funcMap)
    );

    // registered drive outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            motorRun <= 1'b0;
            freewheel <= 1'b1;
            velocityMode <= 1'b0;
            funcOut <= 16'h0000;
        end else begin
            velocityMode <= profile_r;
            funcOut <= funcMap;
            if (profile_r) begin
                motorRun <= state_r == S_OE;
                freewheel <= state_r != S_OE && state_r != S_QS;
            end else begin
                motorRun <= cw[dpci_pkg::CW_RUN_BIT] && state_r != S_FLT && state_r != S_INIT;
                freewheel <= !cw[dpci_pkg::CW_RUN_BIT];
            end
        end
    end

    // read data
    always_comb begin
        unique case (aAddr_r)
            dpci_pkg::OFS_CTRL: hrdata = ctrl_r;
            dpci_pkg::OFS_CMD: hrdata = {16'h0000, cmd_r};
            dpci_pkg::OFS_REF: hrdata = ref_r;
            dpci_pkg::OFS_ASSIGN: hrdata = assign_r[31:0];
            dpci_pkg::OFS_ASSIGN_HI: hrdata = assign_r[63:32];
            dpci_pkg::OFS_STATUS: hrdata = {15'h0000, profile_r, drive_state_word};
            dpci_pkg::OFS_FUNC: hrdata = {16'h0000, funcOut};
            default: hrdata = 32'h0000_0000;
        endcase
    end

    AST_START_SEQ: assert property (@(posedge clk) disable iff (rst)
        $rose(state_r == S_OE) |-> $past(state_r) == S_SO) else $error("enable skipped sequence");
    AST_FAULT: assert property (@(posedge clk) disable iff (rst)
        errDetect |=> state_r == S_FLT) else $error("error not forced");
    AST_CFG: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_SO && cfgWrite && !errDetect && !ctrl_r[dpci_pkg::CTRL_FAULT]) |=> state_r == S_SOD)
        else $error("config change kept switched on");
    AST_REF: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_OE && $past(state_r) == S_SO) |-> $past(ctrl_r[dpci_pkg::CTRL_SEPARATE] || refSeen_r))
        else $error("enable without reference");
    AST_COAST: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_OE && !cw[dpci_pkg::CW_ENOP] && cw[dpci_pkg::CW_ENVOLT] && cw[dpci_pkg::CW_QUICKSTOP]
         && !ctrl_r[dpci_pkg::CTRL_STOPREACT] && !errDetect && !ctrl_r[dpci_pkg::CTRL_FAULT])
        |=> state_r == S_SO) else $error("no coast to switched on");
    AST_HIDDEN: assert property (@(posedge clk) disable iff (rst)
        state_r == S_INIT |-> drive_state_word == dpci_pkg::SW_SOD) else $error("init visible");
    AST_PROFILE: assert property (@(posedge clk) disable iff (rst)
        initCnt_r == dpci_pkg::INIT_CNT_W |=> $stable(profile_r)) else $error("profile changed");
    AST_IORUN: assert property (@(posedge clk) disable iff (rst)
        (!profile_r && cw[0] && state_r == S_SOD) |=> motorRun) else $error("run bit ignored");
    // switched on is entered only from ready or by a coast from enabled
    sequence dpci_seq_so_entry;
        $rose(state_r == S_SO);
    endsequence
    sequence dpci_seq_so_origin;
        $past(state_r) == S_RTSO || $past(state_r) == S_OE;
    endsequence
    AST_SO_ENTRY: assert property (@(posedge clk) disable iff (rst)
        dpci_seq_so_entry |-> dpci_seq_so_origin) else $error("switched on entered out of order");
endmodule
`default_nettype wire

// ---- dpci_pkg.sv ----
// shared constants for the drive profile command interpreter
package dpci_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_REF = 8'h08;
    localparam logic [7:0] OFS_ASSIGN = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_FUNC = 8'h14;
    localparam logic [7:0] OFS_ASSIGN_HI = 8'h18;
    // control register fields
    localparam int CTRL_PROFILE = 0;
    localparam int CTRL_SEPARATE = 1;
    localparam int CTRL_STOPREACT = 2;
    localparam int CTRL_CFGCHG = 3;
    localparam int CTRL_FAULT = 4;
    localparam int CTRL_FAULTRST = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // standardized control word bits
    localparam int CW_SWITCHON = 0;
    localparam int CW_ENVOLT = 1;
    localparam int CW_QUICKSTOP = 2;
    localparam int CW_ENOP = 3;
    localparam int CW_FAULTRST = 7;
    localparam int CW_FIRST_FREE_STD = 11;
    localparam int CW_FIRST_FREE_IO = 1;
    localparam int CW_RUN_BIT = 0;
    // status word codes
    localparam logic [15:0] SW_SOD = 16'h0040;
    localparam logic [15:0] SW_RTSO = 16'h0021;
    localparam logic [15:0] SW_SO = 16'h0023;
    localparam logic [15:0] SW_OE = 16'h0027;
    localparam logic [15:0] SW_QS = 16'h0007;
    localparam logic [15:0] SW_FRA = 16'h000f;
    localparam logic [15:0] SW_FLT = 16'h0008;
    localparam int INIT_CYCLES = 4;
    localparam logic [2:0] INIT_CNT_W = 3'h4;
endpackage

// ---- dpci_func_map.sv ----
// maps assignable control-word bits to function outputs
`timescale 1ns/1ps
`default_nettype none
module dpci_func_map #(
    parameter int NFUNC = 16
) (
    input wire logic [15:0] ctrlWord,
    input wire logic [63:0] assignMap,
    input wire logic firstFree,
    output logic [NFUNC-1:0] funcOut
);
    // each 4-bit field for bits 1 to 15 (only bits 11 to 15 when firstFree is set) names the function driven by that bit
    always_comb begin
        funcOut = '0;
        for (int b = dpci_pkg::CW_FIRST_FREE_IO; b < 16; b++) begin
            if ((firstFree == 1'b0 || b >= dpci_pkg::CW_FIRST_FREE_STD) && ctrlWord[b]) begin
                funcOut[assignMap[b*4 +: 4]] = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- dpci_plc_model.sv ----
// controller model that places control words on every command source
`timescale 1ns/1ps
`default_nettype none
module dpci_plc_model #(
    parameter int NSRC = 5
) (
    input wire logic clk,
    output logic [NSRC*16-1:0] srcWords
);
    // all sources idle until a word is sent
    initial srcWords = '0;
    // one source word, changed just after a rising edge, held until resent
    task automatic send(input int idx, input logic [15:0] w);
        @(posedge clk);
        srcWords[idx*16 +: 16] <= w;
    endtask
endmodule
`default_nettype wire

// ---- dpci_bench.sv ----
// self-checking bench for the drive profile command interpreter
`timescale 1ns/1ps
`default_nettype none
module dpci_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic errDetect = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic motorRun;
    logic freewheel;
    logic velocityMode;
    logic [15:0] funcOut;
    wire logic [79:0] srcWords;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;
    // 50 MHz clock
    always #10 clk = ~clk;
    // device and controller model
    dpci_top #(.NSRC(5)) dpci_top_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .srcWords(srcWords),
        .errDetect(errDetect), .motorRun(motorRun), .freewheel(freewheel),
        .velocityMode(velocityMode), .funcOut(funcOut));
    dpci_plc_model #(.NSRC(5)) dpci_plc_model_i (.clk(clk), .srcWords(srcWords));
    // value compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // single word transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    // poll the state word, bounded
    task automatic sw(input logic [15:0] e);
        for (int n = 0; n < 8; n++) begin
            bus(1'b0, dpci_pkg::OFS_STATUS, 32'h0);
            if (rd[15:0] === e) break;
        end
        chk({16'h0, rd[15:0]}, {16'h0, e});
    endtask
    // bounded wait on the motor output
    task automatic waitRun(input logic v);
        for (int n = 0; n < 20 && motorRun !== v; n++) @(posedge clk);
        chk({31'h0, motorRun}, {31'h0, v});
    endtask
    // reset, then profile setting written while init runs
    task automatic reboot(input logic [31:0] c);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        if (c != 32'h0) bus(1'b1, dpci_pkg::OFS_CTRL, c);
        repeat (8) @(posedge clk);
    endtask
    // terminal-style profile: run bit from every source
    task automatic t_io();
        reboot(32'h0);
        sw(dpci_pkg::SW_SOD);
        bus(1'b1, dpci_pkg::OFS_CTRL, 32'h1);
        sw(dpci_pkg::SW_SOD);
        chk({31'h0, rd[16]}, 32'h0);
        chk({31'h0, velocityMode}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            dpci_plc_model_i.send(i, 16'h0001);
            waitRun(1'b1);
            chk({31'h0, freewheel}, 32'h0);
            dpci_plc_model_i.send(i, 16'h0000);
            waitRun(1'b0);
        end
        @(posedge clk);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h1);
        waitRun(1'b1);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h0);
        waitRun(1'b0);
        // bit 1 to function 5, bit 15 to function 10
        bus(1'b1, dpci_pkg::OFS_ASSIGN, 32'h0000_0050);
        bus(1'b1, dpci_pkg::OFS_ASSIGN_HI, 32'ha000_0000);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h0000_8002);
        bus(1'b0, dpci_pkg::OFS_FUNC, 32'h0);
        chk(rd, 32'h0000_0420);
        chk({16'h0, funcOut}, 32'h0000_0420);
    endtask
    // standard profile: ordered start, config change, stop, fault
    task automatic t_std();
        reboot(32'h1);
        sw(dpci_pkg::SW_SOD);
        chk({31'h0, rd[16]}, 32'h1);
        chk({31'h0, velocityMode}, 32'h1);
        dpci_plc_model_i.send(2, 16'h0001);
        repeat (6) @(posedge clk);
        chk({31'h0, motorRun}, 32'h0);
        dpci_plc_model_i.send(2, 16'h0006);
        sw(dpci_pkg::SW_RTSO);
        dpci_plc_model_i.send(2, 16'h0007);
        sw(dpci_pkg::SW_SO);
        bus(1'b1, dpci_pkg::OFS_CTRL, 32'h1);
        sw(dpci_pkg::SW_SOD);
        dpci_plc_model_i.send(2, 16'h0000);
        @(posedge clk);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h6);
        sw(dpci_pkg::SW_RTSO);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h7);
        sw(dpci_pkg::SW_SO);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'hf);
        repeat (6) @(posedge clk);
        sw(dpci_pkg::SW_SO);
        bus(1'b1, dpci_pkg::OFS_REF, 32'h64);
        sw(dpci_pkg::SW_OE);
        waitRun(1'b1);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h7);
        sw(dpci_pkg::SW_SO);
        repeat (2) @(posedge clk);
        chk({31'h0, freewheel}, 32'h1);
        chk({31'h0, motorRun}, 32'h0);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'hf);
        sw(dpci_pkg::SW_OE);
        errDetect <= 1'b1;
        sw(dpci_pkg::SW_FLT);
        repeat (2) @(posedge clk);
        chk({31'h0, motorRun}, 32'h0);
        errDetect <= 1'b0;
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h0);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h80);
        sw(dpci_pkg::SW_SOD);
    endtask
    // separate channels: enable with no reference, unmapped read
    task automatic t_sep();
        reboot(32'h3);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h6);
        sw(dpci_pkg::SW_RTSO);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h7);
        sw(dpci_pkg::SW_SO);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'hf);
        sw(dpci_pkg::SW_OE);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        // low bits standardized, only bit 11 reaches its function
        bus(1'b1, dpci_pkg::OFS_ASSIGN, 32'h0000_0050);
        bus(1'b1, dpci_pkg::OFS_ASSIGN_HI, 32'h0000_3000);
        bus(1'b1, dpci_pkg::OFS_CMD, 32'h0000_080f);
        bus(1'b0, dpci_pkg::OFS_FUNC, 32'h0);
        chk(rd, 32'h0000_0008);
        sw(dpci_pkg::SW_OE);
    endtask
    // verdict and end of run
    task automatic print_verdict();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    // main sequence
    initial begin
        t_io();
        t_std();
        t_sep();
        print_verdict();
    end
endmodule
`default_nettype wire
